// >>> hdl/lpmc_defines.svh
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH

// Processor clocks per slow-oscillator cycle: 125 MHz over 32.768 kHz, rounded.
// Kept as a plain figure because the exact quotient is not a whole number and integer division would give 3814.
`define LPMC_SLOW_DIV 3815
`define LPMC_DIV_W 12
`define LPMC_DIV_LAST 12'hEE6
`define LPMC_DIV_ZERO 12'h000

// Restart delays in slow-oscillator cycles.
`define LPMC_WAKE_SHORT_TICKS 16
`define LPMC_WAKE_LONG_TICKS 4064
`define LPMC_WAKE_W 12
`define LPMC_WAKE_ZERO 12'h000
`define LPMC_WAKE_ONE 12'h001

// Timer counter.
`define LPMC_TMR_W 16
`define LPMC_TMR_RST_VAL 16'hFFFC
`define LPMC_TMR_ZERO 16'h0000
`define LPMC_TMR_ONE 16'h0001

`define LPMC_NUM_DRV 5
`define LPMC_DRV_OFF 5'h00

`endif

// >>> hdl/lpmc_pkg.sv
package lpmc_pkg;

  typedef enum logic [1:0] {
    LPMC_ST_RUN = 2'b00,
    LPMC_ST_HALT = 2'b01,
    LPMC_ST_PAUSE = 2'b10,
    LPMC_ST_WAKE = 2'b11
  } lpmc_state_e;

  typedef enum logic [2:0] {
    LPMC_SRC_NONE = 3'b000,
    LPMC_SRC_EXT_PIN = 3'b001,
    LPMC_SRC_RTC = 3'b010,
    LPMC_SRC_TIMER = 3'b011,
    LPMC_SRC_SPI = 3'b100,
    LPMC_SRC_RESET = 3'b101
  } lpmc_src_e;

endpackage

// >>> hdl/lpmc_wake_if.sv
`timescale 1ns/1ns
`include "lpmc_defines.svh"

interface lpmc_wake_if;
  logic start;
  logic long_sel;
  logic tick;
  logic done;

  modport ctrl (
    output start,
    output long_sel,
    output tick,
    input done
  );

  modport timer (
    input start,
    input long_sel,
    input tick,
    output done
  );
endinterface

// >>> hdl/lpmc_wake_timer.sv
`timescale 1ns/1ns
`include "lpmc_defines.svh"

// Counts slow-oscillator ticks after a wake; done is a one-cycle pulse.
module lpmc_wake_timer #(
  parameter logic [`LPMC_WAKE_W-1:0] SHORT_TICKS = `LPMC_WAKE_W'(`LPMC_WAKE_SHORT_TICKS),
  parameter logic [`LPMC_WAKE_W-1:0] LONG_TICKS = `LPMC_WAKE_W'(`LPMC_WAKE_LONG_TICKS)
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  lpmc_wake_if.timer wk
);

  logic [`LPMC_WAKE_W-1:0] remain_r;
  logic busy_r;
  logic done_r;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      remain_r <= `LPMC_WAKE_ZERO;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (wk.start)
      begin
        remain_r <= wk.long_sel ? LONG_TICKS : SHORT_TICKS;
        busy_r <= 1'b1;
      end
      else if (busy_r && wk.tick)
      begin
        if (remain_r == `LPMC_WAKE_ONE)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        remain_r <= remain_r - `LPMC_WAKE_ONE;
      end
    end
  end

  assign wk.done = done_r;

endmodule // lpmc_wake_timer

// >>> hdl/lpmc_low_power_ctrl.sv
`timescale 1ns/1ns
`include "lpmc_defines.svh"

// Operation
// - Timer counter holds during halt and resumes from that value after interrupt wake.
// - A reset ending halt loads the timer counter with FFFC hex.
// - Capture edge in halt only arms; flag and value appear after interrupt wake.
// - External reset ending halt discards any armed capture; no flag, no data.
// - Real-time clock runs from 32.768 kHz and keeps running in halt if oscillator kept.
// - With oscillator-stop selected, halt disables the slow oscillator and real-time clock.
// - Halt shuts the serial baud generator; master transfers freeze until halt ends.
// - A reset ending halt clears serial control and status, disabling the port.
// - A serial slave keeps shifting with the external clock during halt.
// - Slave transfer done in halt sets no flag until an external pin wakes.
// - Serial write-collision and mode-fault detection are inactive during halt.
// - Enabled output drivers keep driving throughout halt.
// - Pause stops only CPU execution; clock, timer, serial, real-time clock keep going.
// - Entering pause clears the interrupt mask bit.
// - CPU registers, memory and parallel lines stay frozen during pause.
// - Pause ends on external pins, real-time clock, timer or serial interrupt.
// - Non-reset pause wake resumes prior state; reset wake returns all to reset state.
// - Real-time clock cannot be disabled in pause; timer and serial may be.
// - Halt turns off the processor clock and freezes registers, memory and lines.
// - Entering halt clears the interrupt mask bit, enabling pin and clock wakes.
// - Halt wake waits 16 slow cycles if oscillator ran, else 4064; an external reset wake here always waits the long 4064.
// - Halt ends only on external pins, real-time clock interrupt or external reset.
module lpmc_low_power_ctrl #(
  parameter logic [`LPMC_WAKE_W-1:0] WAKE_LONG_TICKS = `LPMC_WAKE_W'(`LPMC_WAKE_LONG_TICKS)
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic halt_req_i,
  input wire logic pause_req_i,
  input wire logic osc_stop_select_i,
  input wire logic ext_reset_n_i,
  input wire logic ext_irq_n_i,
  input wire logic ext_interrupt_a_n_i,
  input wire logic ext_interrupt_b_n_i,
  input wire logic rtc_irq_i,
  input wire logic timer_irq_i,
  input wire logic spi_irq_i,
  input wire logic timer_enable_i,
  input wire logic capture_input_pin_i,
  input wire logic capture_flag_clr_i,
  input wire logic spi_enable_i,
  input wire logic spi_slave_done_i,
  input wire logic spi_flag_clr_i,
  input wire logic [`LPMC_NUM_DRV-1:0] drv_oe_i,
  output logic proc_clk_en_o,
  output logic cpu_hold_o,
  output logic imask_clear_o,
  output logic wake_valid_o,
  output lpmc_pkg::lpmc_src_e wake_src_o,
  output logic slow_osc_run_o,
  output logic rtc_tick_o,
  output logic [`LPMC_TMR_W-1:0] timer_count_o,
  output logic capture_flag_o,
  output logic [`LPMC_TMR_W-1:0] capture_value_o,
  output logic spi_baud_en_o,
  output logic spi_enable_o,
  output logic spi_prot_en_o,
  output logic spi_done_flag_o,
  output logic [`LPMC_NUM_DRV-1:0] drv_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State and wake registration.

  lpmc_pkg::lpmc_state_e state_r;
  lpmc_pkg::lpmc_state_e state_nxt;
  lpmc_pkg::lpmc_src_e src_r;
  logic pin_wake_r;
  logic rtc_wake_r;
  logic tmr_wake_r;
  logic spi_wake_r;
  logic rst_wake_r;
  logic halt_wake;
  logic pause_wake;
  logic halted;
  logic wake_long_r;
  logic cap_prev_r;
  logic cap_edge;
  lpmc_wake_if wk ();

  assign halted = (state_r == lpmc_pkg::LPMC_ST_HALT);

  // Each source is sampled once so a request that drops while the restart
  // decision is made is still seen on the next edge.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_wake_r <= 1'b0;
      rtc_wake_r <= 1'b0;
      tmr_wake_r <= 1'b0;
      spi_wake_r <= 1'b0;
      rst_wake_r <= 1'b0;
    end
    else
    begin
      pin_wake_r <= !ext_irq_n_i || !ext_interrupt_a_n_i || !ext_interrupt_b_n_i;
      rtc_wake_r <= rtc_irq_i;
      tmr_wake_r <= timer_irq_i;
      spi_wake_r <= spi_irq_i;
      rst_wake_r <= !ext_reset_n_i;
    end
  end

  assign halt_wake = pin_wake_r || rtc_wake_r || rst_wake_r;
  assign pause_wake = halt_wake || tmr_wake_r || spi_wake_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      lpmc_pkg::LPMC_ST_RUN:
      begin
        if (rst_wake_r)
          state_nxt = lpmc_pkg::LPMC_ST_WAKE;
        else if (halt_req_i)
          state_nxt = lpmc_pkg::LPMC_ST_HALT;
        else if (pause_req_i)
          state_nxt = lpmc_pkg::LPMC_ST_PAUSE;
      end
      lpmc_pkg::LPMC_ST_HALT:
      begin
        if (halt_wake)
          state_nxt = lpmc_pkg::LPMC_ST_WAKE;
      end
      lpmc_pkg::LPMC_ST_PAUSE:
      begin
        if (pause_wake)
          state_nxt = lpmc_pkg::LPMC_ST_RUN;
      end
      lpmc_pkg::LPMC_ST_WAKE:
      begin
        if (wk.done)
          state_nxt = lpmc_pkg::LPMC_ST_RUN;
      end
      default:
        state_nxt = lpmc_pkg::LPMC_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state_r <= lpmc_pkg::LPMC_ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Wake source, reported for vectoring once the CPU is released.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      src_r <= lpmc_pkg::LPMC_SRC_NONE;
    else if (state_r != lpmc_pkg::LPMC_ST_WAKE && state_nxt != state_r
             && state_nxt != lpmc_pkg::LPMC_ST_HALT && state_nxt != lpmc_pkg::LPMC_ST_PAUSE)
    begin
      if (rst_wake_r)
        src_r <= lpmc_pkg::LPMC_SRC_RESET;
      else if (pin_wake_r)
        src_r <= lpmc_pkg::LPMC_SRC_EXT_PIN;
      else if (rtc_wake_r)
        src_r <= lpmc_pkg::LPMC_SRC_RTC;
      else if (tmr_wake_r)
        src_r <= lpmc_pkg::LPMC_SRC_TIMER;
      else
        src_r <= lpmc_pkg::LPMC_SRC_SPI;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wake_valid_o <= 1'b0;
      wake_src_o <= lpmc_pkg::LPMC_SRC_NONE;
      imask_clear_o <= 1'b0;
    end
    else
    begin
      wake_valid_o <= (state_r != lpmc_pkg::LPMC_ST_RUN) && (state_nxt == lpmc_pkg::LPMC_ST_RUN);
      if (state_r == lpmc_pkg::LPMC_ST_PAUSE && state_nxt == lpmc_pkg::LPMC_ST_RUN)
      begin
        if (rst_wake_r)
          wake_src_o <= lpmc_pkg::LPMC_SRC_RESET;
        else if (pin_wake_r)
          wake_src_o <= lpmc_pkg::LPMC_SRC_EXT_PIN;
        else if (rtc_wake_r)
          wake_src_o <= lpmc_pkg::LPMC_SRC_RTC;
        else if (tmr_wake_r)
          wake_src_o <= lpmc_pkg::LPMC_SRC_TIMER;
        else
          wake_src_o <= lpmc_pkg::LPMC_SRC_SPI;
      end
      else if (state_r == lpmc_pkg::LPMC_ST_WAKE && wk.done)
        wake_src_o <= src_r;
      imask_clear_o <= (state_r == lpmc_pkg::LPMC_ST_RUN) && !rst_wake_r
                       && (halt_req_i || pause_req_i);
    end
  end

  // The CPU core freezes its registers, memory and parallel lines while held.
  assign cpu_hold_o = (state_r != lpmc_pkg::LPMC_ST_RUN);
  assign proc_clk_en_o = !halted;

  ////////////////////////////////////////////////////////////////////////////
  // Slow oscillator, real-time clock tick and restart delay.

  logic [`LPMC_DIV_W-1:0] div_r;
  logic osc_run;

  // The oscillator is only stopped by halt with the stop selection; pause
  // never touches it, so the real-time clock cannot be disabled there.
  assign osc_run = !(halted && osc_stop_select_i);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      div_r <= `LPMC_DIV_ZERO;
      rtc_tick_o <= 1'b0;
    end
    else if (!osc_run)
    begin
      div_r <= `LPMC_DIV_ZERO;
      rtc_tick_o <= 1'b0;
    end
    else
    begin
      rtc_tick_o <= (div_r == `LPMC_DIV_LAST);
      div_r <= (div_r == `LPMC_DIV_LAST) ? `LPMC_DIV_ZERO : div_r + 12'h001;
    end
  end

  assign slow_osc_run_o = osc_run;

  // A long restart follows an oscillator stop or an external reset wake from run or halt.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      wake_long_r <= 1'b0;
    else if (state_nxt == lpmc_pkg::LPMC_ST_WAKE && state_r != lpmc_pkg::LPMC_ST_WAKE)
      wake_long_r <= rst_wake_r || (halted && osc_stop_select_i);
  end

  assign wk.start = (state_nxt == lpmc_pkg::LPMC_ST_WAKE) && (state_r != lpmc_pkg::LPMC_ST_WAKE);
  assign wk.long_sel = rst_wake_r || (halted && osc_stop_select_i);
  assign wk.tick = rtc_tick_o;

  lpmc_wake_timer #(
    .LONG_TICKS(WAKE_LONG_TICKS)
  ) u_wake_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wk(wk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Free-running timer and input capture.

  logic cap_armed_r;
  logic [`LPMC_TMR_W-1:0] cap_armed_val_r;
  logic arm_release;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      timer_count_o <= `LPMC_TMR_RST_VAL;
    else if (rst_wake_r)
      timer_count_o <= `LPMC_TMR_RST_VAL;
    else if (!halted && timer_enable_i)
      timer_count_o <= timer_count_o + `LPMC_TMR_ONE;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      cap_prev_r <= 1'b0;
    else
      cap_prev_r <= capture_input_pin_i;
  end

  assign cap_edge = capture_input_pin_i && !cap_prev_r;
  // An interrupt wake after an oscillator stop also takes the long delay, so
  // the release keys on the wake source rather than on the delay length.
  assign arm_release = (state_r == lpmc_pkg::LPMC_ST_WAKE) && wk.done
                       && (src_r != lpmc_pkg::LPMC_SRC_RESET);

  // Only the first edge during halt is kept; it becomes visible after an interrupt wake.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || rst_wake_r)
    begin
      cap_armed_r <= 1'b0;
      cap_armed_val_r <= `LPMC_TMR_ZERO;
    end
    else if (halted && cap_edge && !cap_armed_r)
    begin
      cap_armed_r <= 1'b1;
      cap_armed_val_r <= timer_count_o;
    end
    else if (arm_release || state_r == lpmc_pkg::LPMC_ST_RUN)
      cap_armed_r <= 1'b0;
  end

  // Set wins over a clear in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || rst_wake_r)
    begin
      capture_flag_o <= 1'b0;
      capture_value_o <= `LPMC_TMR_ZERO;
    end
    else if (cap_armed_r && arm_release)
    begin
      capture_flag_o <= 1'b1;
      capture_value_o <= cap_armed_val_r;
    end
    else if (!halted && cap_edge)
    begin
      capture_flag_o <= 1'b1;
      capture_value_o <= timer_count_o;
    end
    else if (capture_flag_clr_i)
      capture_flag_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port gating.

  logic spi_pend_r;

  // The baud generator stops in halt, so a master transfer simply stalls
  // and picks up where it was; a slave keeps shifting on the external clock.
  assign spi_baud_en_o = !halted && spi_enable_o;
  assign spi_prot_en_o = !halted && spi_enable_o;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || rst_wake_r)
      spi_enable_o <= 1'b0;
    else
      spi_enable_o <= spi_enable_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || rst_wake_r)
      spi_pend_r <= 1'b0;
    else if (halted && spi_slave_done_i)
      spi_pend_r <= 1'b1;
    else if (arm_release && src_r == lpmc_pkg::LPMC_SRC_EXT_PIN)
      spi_pend_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || rst_wake_r)
      spi_done_flag_o <= 1'b0;
    else if (spi_pend_r && arm_release && src_r == lpmc_pkg::LPMC_SRC_EXT_PIN)
      spi_done_flag_o <= 1'b1;
    else if (!halted && spi_slave_done_i)
      spi_done_flag_o <= 1'b1;
    else if (spi_flag_clr_i)
      spi_done_flag_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drivers are not touched by either low-power state.

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      drv_oe_o <= `LPMC_DRV_OFF;
    else
      drv_oe_o <= drv_oe_i;
  end

endmodule // lpmc_low_power_ctrl

// >>> bench/lpmc_irq_model.sv
`timescale 1ns/1ns

// Stands in for the interrupt sources: a request is a level that stays up until
// the service routine runs, so it is only dropped once the CPU is released.
module lpmc_irq_model (
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [2:0] line_i,
  input wire logic cpu_hold_i,
  output logic [5:0] irq_o
);
  initial irq_o = 6'h00;

  always @(posedge clk_i)
  begin
    if (fire_i)
      irq_o <= 6'h01 << line_i;
    else if (!cpu_hold_i)
      irq_o <= 6'h00;
  end
endmodule // lpmc_irq_model

// >>> bench/lpmc_monitor.sv
`timescale 1ns/1ns
`include "lpmc_defines.svh"

module lpmc_monitor (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic halt_req_i,
  input wire logic pause_req_i,
  input wire logic ext_reset_n_i,
  input wire logic osc_stop_select_i,
  input wire logic [`LPMC_NUM_DRV-1:0] drv_oe_i,
  input wire logic proc_clk_en_o,
  input wire logic cpu_hold_o,
  input wire logic imask_clear_o,
  input wire logic wake_valid_o,
  input wire logic slow_osc_run_o,
  input wire logic [`LPMC_TMR_W-1:0] timer_count_o,
  input wire logic capture_flag_o,
  input wire logic spi_baud_en_o,
  input wire logic spi_enable_o,
  input wire logic spi_done_flag_o,
  input wire logic [`LPMC_NUM_DRV-1:0] drv_oe_o
);
  default clocking mc @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_halt_in;
    !cpu_hold_o && halt_req_i && ext_reset_n_i && $past(ext_reset_n_i)
      |=> !proc_clk_en_o && cpu_hold_o && imask_clear_o;
  endproperty
  a_halt_in: assert property (p_halt_in) else $error("bad halt entry");

  property p_pause_in;
    !cpu_hold_o && pause_req_i && !halt_req_i && ext_reset_n_i && $past(ext_reset_n_i)
      |=> cpu_hold_o && proc_clk_en_o && imask_clear_o;
  endproperty
  a_pause_in: assert property (p_pause_in) else $error("bad pause entry");

  property p_tmr_hold;
    !proc_clk_en_o ##1 !proc_clk_en_o |-> $stable(timer_count_o);
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("timer moved in halt");

  property p_drv_keep;
    !proc_clk_en_o ##1 !proc_clk_en_o |-> drv_oe_o == $past(drv_oe_i);
  endproperty
  a_drv_keep: assert property (p_drv_keep) else $error("driver dropped in halt");

  property p_baud;
    spi_baud_en_o == (spi_enable_o && proc_clk_en_o);
  endproperty
  a_baud: assert property (p_baud) else $error("baud enable wrong");

  property p_osc;
    slow_osc_run_o == (proc_clk_en_o || !osc_stop_select_i);
  endproperty
  a_osc: assert property (p_osc) else $error("slow oscillator wrong");

  property p_rst_wake;
    $fell(ext_reset_n_i) |-> ##2 timer_count_o == `LPMC_TMR_RST_VAL && !capture_flag_o
      && !spi_done_flag_o && !spi_enable_o;
  endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("reset wake state wrong");

  property p_wake_valid;
    $fell(cpu_hold_o) |-> wake_valid_o ##1 !wake_valid_o;
  endproperty
  a_wake_valid: assert property (p_wake_valid) else $error("wake pulse wrong");
endmodule // lpmc_monitor

bind lpmc_low_power_ctrl lpmc_monitor u_mon (
  .clk_i, .sys_rst_i, .halt_req_i, .pause_req_i, .ext_reset_n_i, .osc_stop_select_i,
  .drv_oe_i, .proc_clk_en_o, .cpu_hold_o, .imask_clear_o, .wake_valid_o, .slow_osc_run_o,
  .timer_count_o, .capture_flag_o, .spi_baud_en_o, .spi_enable_o, .spi_done_flag_o,
  .drv_oe_o
);

// >>> bench/lpmc_low_power_ctrl_tb_top.sv
`timescale 1ns/1ns
`include "lpmc_defines.svh"

`define CHK(nm, got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected %s: expected %0h, seen %0h", nm, (exp), (got)); end end

module lpmc_low_power_ctrl_tb_top;
  typedef struct {logic [2:0] line; lpmc_pkg::lpmc_src_e src;} lpmc_row_s;
  // Short restart delay keeps the reset-wake case near fifteen thousand cycles.
  localparam logic [`LPMC_WAKE_W-1:0] LONG_TICKS = 12'h004;
  lpmc_row_s rows [6];
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  logic [15:0] t0;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic halt_req_i = 1'b0;
  logic pause_req_i = 1'b0;
  logic osc_stop_select_i = 1'b0;
  logic ext_reset_n_i = 1'b1;
  logic capture_input_pin_i = 1'b0;
  logic capture_flag_clr_i = 1'b0;
  logic spi_enable_i = 1'b1;
  logic spi_slave_done_i = 1'b0;
  logic spi_flag_clr_i = 1'b0;
  logic [4:0] drv_oe_i = 5'h00;
  logic fire_i = 1'b0;
  logic [2:0] line_i = 3'h0;
  logic [5:0] irq;
  logic proc_clk_en_o, cpu_hold_o, imask_clear_o, wake_valid_o, slow_osc_run_o, rtc_tick_o;
  logic capture_flag_o, spi_baud_en_o, spi_enable_o, spi_prot_en_o, spi_done_flag_o;
  logic [15:0] timer_count_o, capture_value_o;
  logic [4:0] drv_oe_o;
  lpmc_pkg::lpmc_src_e wake_src_o;

  lpmc_irq_model u_irq (.clk_i, .fire_i, .line_i, .cpu_hold_i(cpu_hold_o), .irq_o(irq));

  lpmc_low_power_ctrl #(.WAKE_LONG_TICKS(LONG_TICKS)) u_dut (
    .clk_i, .sys_rst_i, .halt_req_i, .pause_req_i, .osc_stop_select_i, .ext_reset_n_i,
    .ext_irq_n_i(~irq[0]), .ext_interrupt_a_n_i(~irq[1]), .ext_interrupt_b_n_i(~irq[2]),
    .rtc_irq_i(irq[3]), .timer_irq_i(irq[4]), .spi_irq_i(irq[5]), .timer_enable_i(1'b1),
    .capture_input_pin_i, .capture_flag_clr_i, .spi_enable_i, .spi_slave_done_i,
    .spi_flag_clr_i, .drv_oe_i, .proc_clk_en_o, .cpu_hold_o, .imask_clear_o, .wake_valid_o,
    .wake_src_o, .slow_osc_run_o, .rtc_tick_o, .timer_count_o, .capture_flag_o,
    .capture_value_o, .spi_baud_en_o, .spi_enable_o, .spi_prot_en_o, .spi_done_flag_o,
    .drv_oe_o
  );

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic count_ticks(output int c);
    c = 0;
    while (!proc_clk_en_o) step(1);
    while (cpu_hold_o)
    begin
      if (rtc_tick_o === 1'b1) c++;
      step(1);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    rows = '{'{3'h0, lpmc_pkg::LPMC_SRC_EXT_PIN}, '{3'h1, lpmc_pkg::LPMC_SRC_EXT_PIN},
             '{3'h2, lpmc_pkg::LPMC_SRC_EXT_PIN}, '{3'h3, lpmc_pkg::LPMC_SRC_RTC},
             '{3'h4, lpmc_pkg::LPMC_SRC_TIMER}, '{3'h5, lpmc_pkg::LPMC_SRC_SPI}};
    step(2);
    sys_rst_i = 1'b0;
    `CHK("tmr_rst", timer_count_o, `LPMC_TMR_RST_VAL);
    step(1);
    foreach (rows[i])
    begin
      pause_req_i = 1'b1;
      step(1);
      pause_req_i = 1'b0;
      `CHK("imask", imask_clear_o, 1'b1);
      t0 = timer_count_o;
      step(3);
      `CHK("tmr_runs", timer_count_o != t0, 1'b1);
      `CHK("paused", cpu_hold_o, 1'b1);
      line_i = rows[i].line;
      fire_i = 1'b1;
      step(1);
      fire_i = 1'b0;
      while (cpu_hold_o) step(1);
      `CHK("wvalid", wake_valid_o, 1'b1);
      `CHK("wsrc", wake_src_o, rows[i].src);
      step(2);
    end
    $display("test pause wakes done");
    drv_oe_i = 5'h15;
    halt_req_i = 1'b1;
    step(1);
    halt_req_i = 1'b0;
    `CHK("clk_off", proc_clk_en_o, 1'b0);
    t0 = timer_count_o;
    capture_input_pin_i = 1'b1;
    spi_slave_done_i = 1'b1;
    line_i = 3'h4;
    fire_i = 1'b1;
    step(1);
    capture_input_pin_i = 1'b0;
    spi_slave_done_i = 1'b0;
    fire_i = 1'b0;
    step(20);
    `CHK("frozen", timer_count_o, t0);
    `CHK("halted", proc_clk_en_o, 1'b0);
    `CHK("capflag", capture_flag_o, 1'b0);
    `CHK("spiflag", spi_done_flag_o, 1'b0);
    `CHK("oscrun", slow_osc_run_o, 1'b1);
    `CHK("baud", spi_baud_en_o, 1'b0);
    `CHK("prot", spi_prot_en_o, 1'b0);
    `CHK("drv", drv_oe_o, 5'h15);
    line_i = 3'h1;
    fire_i = 1'b1;
    step(1);
    fire_i = 1'b0;
    count_ticks(n);
    `CHK("ticks", n, `LPMC_WAKE_SHORT_TICKS);
    `CHK("wv_halt", wake_valid_o, 1'b1);
    step(1);
    `CHK("src_pin", wake_src_o, lpmc_pkg::LPMC_SRC_EXT_PIN);
    `CHK("cap_late", capture_flag_o, 1'b1);
    `CHK("cap_val", capture_value_o, t0);
    `CHK("spi_late", spi_done_flag_o, 1'b1);
    capture_flag_clr_i = 1'b1;
    spi_flag_clr_i = 1'b1;
    step(1);
    capture_flag_clr_i = 1'b0;
    spi_flag_clr_i = 1'b0;
    step(1);
    `CHK("cap_clr", capture_flag_o, 1'b0);
    $display("test halt pin wake done");
    osc_stop_select_i = 1'b1;
    halt_req_i = 1'b1;
    step(1);
    halt_req_i = 1'b0;
    capture_input_pin_i = 1'b1;
    spi_slave_done_i = 1'b1;
    step(1);
    capture_input_pin_i = 1'b0;
    spi_slave_done_i = 1'b0;
    `CHK("oscoff", slow_osc_run_o, 1'b0);
    ext_reset_n_i = 1'b0;
    step(1);
    ext_reset_n_i = 1'b1;
    step(1);
    `CHK("tmr_ld", timer_count_o, `LPMC_TMR_RST_VAL);
    `CHK("capnone", capture_flag_o, 1'b0);
    `CHK("capval0", capture_value_o, 16'h0000);
    `CHK("spioff", spi_enable_o, 1'b0);
    count_ticks(n);
    `CHK("ticks_long", n, int'(LONG_TICKS));
    step(1);
    `CHK("src_rst", wake_src_o, lpmc_pkg::LPMC_SRC_RESET);
    $display("test halt reset wake done");
    summarize();
  end
endmodule // lpmc_low_power_ctrl_tb_top
